//--- cbpe_engine.v
// bit protocol engine: idle, arbitration, stuffing, crc, error/overload
// assumes bit_tick is one core_clk pulse at each sample point and that
// can_rx is already synchronised by the bit-timing logic (same domain)
`timescale 1ns/100ps
`default_nettype none
`include "cbpe_map.vh"
module cbpe_engine
#(
  parameter MAX_DATA_BITS = 64
)
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        bit_tick,
  input  wire        can_rx,
  output wire        can_tx,
  output wire        hard_sync,
  input  wire        tx_req,
  input  wire [10:0] tx_id,
  input  wire        tx_rtr,
  input  wire [3:0]  tx_dlc,
  input  wire [63:0] tx_data,
  output wire        tx_done,
  output wire        tx_retry,
  output wire        arb_lost,
  output wire [10:0] rx_id,
  output wire        rx_rtr,
  output wire [3:0]  rx_dlc,
  output wire [63:0] rx_data,
  output wire        rx_valid,
  input  wire [7:0]  tx_err_cnt,
  input  wire [7:0]  rx_err_cnt,
  output wire        err_bit,
  output wire        err_stuff,
  output wire        err_crc,
  output wire        err_form,
  output wire        overload_seen,
  output wire        bus_idle
);
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_ARB   = 10'h002;
  localparam [9:0] S_CTRL  = 10'h004;
  localparam [9:0] S_DATA  = 10'h008;
  localparam [9:0] S_CRC   = 10'h010;
  localparam [9:0] S_TAIL  = 10'h020;
  localparam [9:0] S_FLAG  = 10'h040;
  localparam [9:0] S_DWAIT = 10'h080;
  localparam [9:0] S_DELIM = 10'h100;
  localparam [9:0] S_INTER = 10'h200;
  // tail positions: 0 crc delim, 1 ack slot, 2 ack delim, 3..9 end of frame
  localparam [3:0] T_ACK_SLOT = 4'd1;
  localparam [3:0] T_ACK_DEL  = 4'd2;
  localparam [3:0] T_LAST     = 4'd9;

  reg  [9:0]  state_reg;
  reg  [6:0]  cnt_reg;
  reg  [2:0]  run_reg;
  reg         last_reg;
  reg         drive_reg;
  reg         txing_reg;
  reg         is_ovl_reg;
  reg         passive_reg;
  reg         crc_pend_reg;
  reg         retry_reg;
  reg         done_reg;
  reg         lost_reg;
  reg         rxv_reg;
  reg  [3:0]  ebits_reg;
  reg         ovl_reg;
  reg  [18:0] arb_sh_reg;
  reg  [5:0]  ctl_sh_reg;
  reg  [63:0] dat_sh_reg;
  reg  [14:0] crc_rx_reg;
  reg         rx_prev_reg;
  reg         tick_d_reg;

  wire [14:0] crc_val;
  wire        stuffed;
  wire        stuff_slot;
  wire        tx_bit;
  wire        mismatch;
  wire        use_passive;
  wire [6:0]  data_len;
  reg         crc_clr;
  reg         crc_en;

  // 18 arbitration/control bits before data; dlc over eight reads as eight
  function [6:0] data_bits;
    input [3:0] dlc;
    input       rtr;
    begin
      if (rtr)
        data_bits = 7'd0;
      else if (dlc > 4'd8)
        data_bits = 7'd64;
      else
        data_bits = {dlc, 3'b000};
    end
  endfunction

  assign stuffed = (state_reg == S_ARB) || (state_reg == S_CTRL) ||
                   (state_reg == S_DATA) || (state_reg == S_CRC);
  // a run ending on the last crc bit still owes one stuff bit
  assign stuff_slot = (stuffed || (state_reg == S_TAIL && cnt_reg == 7'd0)) &&
                      (run_reg == `CBPE_STUFF_LEN);
  assign use_passive = (tx_err_cnt > `CBPE_PASSIVE_LIM) ||
                       (rx_err_cnt > `CBPE_PASSIVE_LIM);
  wire [3:0] rx_dlc_w = ctl_sh_reg[3:0];
  wire       rx_rtr_w = arb_sh_reg[0];
  assign data_len = data_bits(rx_dlc_w, rx_rtr_w);

  // next bit to send from the frame currently owned by this node
  assign tx_bit = stuff_slot ? ~last_reg :
                  (state_reg == S_ARB)  ? arb_sh_reg[18] :
                  (state_reg == S_CTRL) ? ctl_sh_reg[5] :
                  (state_reg == S_DATA) ? dat_sh_reg[63] :
                  (state_reg == S_CRC)  ? crc_val[4'd14 - cnt_reg[3:0]] :
                  1'b1;
  assign mismatch = txing_reg && (drive_reg != can_rx);
  assign can_tx = drive_reg;
  assign hard_sync = (state_reg == S_IDLE) && bit_tick && !can_rx;
  assign tx_done = done_reg;
  assign tx_retry = retry_reg;
  assign arb_lost = lost_reg;
  assign rx_id = arb_sh_reg[11:1];
  assign rx_rtr = arb_sh_reg[0];
  assign rx_dlc = ctl_sh_reg[3:0];
  assign rx_data = dat_sh_reg;
  assign rx_valid = rxv_reg;
  assign err_bit = ebits_reg[0];
  assign err_stuff = ebits_reg[1];
  assign err_crc = ebits_reg[2];
  assign err_form = ebits_reg[3];
  assign overload_seen = ovl_reg;
  assign bus_idle = (state_reg == S_IDLE);

  always @*
  begin
    crc_clr = bit_tick && (state_reg == S_IDLE);
    crc_en = bit_tick && !stuff_slot && !txing_reg &&
             ((state_reg == S_ARB) || (state_reg == S_CTRL) ||
              (state_reg == S_DATA));
  end

  cbpe_crc15 u_crc
  (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (crc_clr),
    .shift_en (crc_en || (bit_tick && txing_reg && !stuff_slot &&
               (state_reg == S_ARB || state_reg == S_CTRL ||
                state_reg == S_DATA))),
    .bit_in   (can_rx),
    .crc      (crc_val)
  );

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= S_IDLE;
      cnt_reg      <= 7'd0;
      run_reg      <= 3'd0;
      last_reg     <= 1'b1;
      drive_reg    <= 1'b1;
      txing_reg    <= 1'b0;
      is_ovl_reg   <= 1'b0;
      passive_reg  <= 1'b0;
      crc_pend_reg <= 1'b0;
      retry_reg    <= 1'b0;
      done_reg     <= 1'b0;
      lost_reg     <= 1'b0;
      rxv_reg      <= 1'b0;
      ebits_reg    <= 4'h0;
      ovl_reg      <= 1'b0;
      arb_sh_reg   <= 19'h00000;
      ctl_sh_reg   <= 6'h00;
      dat_sh_reg   <= 64'h0000000000000000;
      crc_rx_reg   <= 15'h0000;
      rx_prev_reg  <= 1'b1;
      tick_d_reg   <= 1'b0;
    end
    else
    begin
      tick_d_reg <= bit_tick;
      // next level is chosen one clock after the tick, once shifts and
      // crc hold the bit just sampled; flag drives are set on the tick
      if (tick_d_reg && (stuffed || state_reg == S_TAIL))
        drive_reg <= txing_reg ? tx_bit :
                     !(state_reg == S_TAIL && cnt_reg[3:0] == T_ACK_SLOT &&
                       !crc_pend_reg);
      retry_reg <= 1'b0;
      done_reg  <= 1'b0;
      lost_reg  <= 1'b0;
      rxv_reg   <= 1'b0;
      ebits_reg <= 4'h0;
      ovl_reg   <= 1'b0;
      if (bit_tick)
      begin
        rx_prev_reg <= can_rx;
        // stuff run counter over the bus level as seen
        if (stuff_slot || !stuffed)
          run_reg <= 3'd1;
        else if (can_rx == last_reg)
          run_reg <= run_reg + 3'd1;
        else
          run_reg <= 3'd1;
        last_reg <= can_rx;
        case (state_reg)
          S_IDLE:
          begin
            if (!can_rx)
            begin
              // start bit seen: this node transmits only if it drove it
              txing_reg  <= !drive_reg;
              state_reg  <= S_ARB;
              cnt_reg    <= 7'd0;
              run_reg    <= 3'd1;
              crc_pend_reg <= 1'b0;
              if (drive_reg)
                arb_sh_reg <= 19'h00000;
              drive_reg  <= !drive_reg ? tx_id[10] : 1'b1;
              if (!drive_reg)
                arb_sh_reg <= {tx_id, tx_rtr, 7'h00};
              if (!drive_reg)
                ctl_sh_reg <= {2'b00, tx_dlc};
              if (!drive_reg)
                dat_sh_reg <= tx_data;
            end
            else if (tx_req && drive_reg)
              drive_reg <= 1'b0;
          end
          S_ARB, S_CTRL, S_DATA, S_CRC:
          begin
            if (stuff_slot && (can_rx == last_reg))
            begin
              ebits_reg[1] <= 1'b1;
              state_reg <= S_FLAG;
              cnt_reg <= 7'd0;
              drive_reg <= use_passive;
              passive_reg <= use_passive;
              retry_reg <= txing_reg;
            end
            else if (mismatch && !(state_reg == S_ARB && drive_reg &&
                     !stuff_slot))
            begin
              ebits_reg[0] <= 1'b1;
              state_reg <= S_FLAG;
              cnt_reg <= 7'd0;
              drive_reg <= use_passive;
              passive_reg <= use_passive;
              retry_reg <= txing_reg;
            end
            else
            begin
              if (mismatch)
              begin
                txing_reg <= 1'b0;
                lost_reg  <= 1'b1;
              end
              if (!stuff_slot)
              begin
                cnt_reg <= cnt_reg + 7'd1;
                case (state_reg)
                  S_ARB:
                  begin
                    arb_sh_reg <= {arb_sh_reg[17:0], can_rx};
                    if (cnt_reg == 7'd11)
                    begin
                      // 12 bits: id then request bit, rest kept aligned
                      arb_sh_reg <= {7'h00, arb_sh_reg[10:0], can_rx};
                      state_reg <= S_CTRL;
                      cnt_reg <= 7'd0;
                    end
                  end
                  S_CTRL:
                  begin
                    ctl_sh_reg <= {ctl_sh_reg[4:0], can_rx};
                    if (cnt_reg == 7'd5)
                    begin
                      cnt_reg <= 7'd0;
                      state_reg <= (data_bits({ctl_sh_reg[2:0], can_rx},
                                    arb_sh_reg[0]) == 7'd0) ? S_CRC : S_DATA;
                    end
                  end
                  S_DATA:
                  begin
                    dat_sh_reg <= {dat_sh_reg[62:0], can_rx};
                    if (cnt_reg == data_len - 7'd1)
                    begin
                      cnt_reg <= 7'd0;
                      state_reg <= S_CRC;
                    end
                  end
                  default:
                  begin
                    crc_rx_reg <= {crc_rx_reg[13:0], can_rx};
                    if (cnt_reg == {3'd0, `CBPE_CRC_LEN} - 7'd1)
                    begin
                      cnt_reg <= 7'd0;
                      state_reg <= S_TAIL;
                    end
                  end
                endcase
              end
            end
          end
          S_TAIL:
          begin
            if (cnt_reg == 7'd0 && !stuff_slot && !txing_reg &&
                (crc_rx_reg != crc_val))
              crc_pend_reg <= 1'b1;
            if (!stuff_slot)
              cnt_reg <= cnt_reg + 7'd1;
            if (stuff_slot)
            begin
              if (can_rx == last_reg)
              begin
                ebits_reg[1] <= 1'b1;
                state_reg <= S_FLAG;
                cnt_reg <= 7'd0;
                drive_reg <= use_passive;
                passive_reg <= use_passive;
                retry_reg <= txing_reg;
              end
            end
            else if (!can_rx && cnt_reg[3:0] != T_ACK_SLOT)
            begin
              ebits_reg[3] <= 1'b1;
              state_reg <= S_FLAG;
              cnt_reg <= 7'd0;
              drive_reg <= use_passive;
              passive_reg <= use_passive;
              retry_reg <= txing_reg;
            end
            else if (cnt_reg[3:0] == T_ACK_DEL && crc_pend_reg)
            begin
              ebits_reg[2] <= 1'b1;
              state_reg <= S_FLAG;
              cnt_reg <= 7'd0;
              drive_reg <= use_passive;
              passive_reg <= use_passive;
            end
            else if (cnt_reg[3:0] == T_LAST)
            begin
              done_reg  <= txing_reg;
              rxv_reg   <= !txing_reg;
              txing_reg <= 1'b0;
              state_reg <= S_INTER;
              cnt_reg   <= 7'd0;
            end
          end
          S_FLAG:
          begin
            // active flag: six dominant driven; passive: six equal seen
            if (passive_reg)
            begin
              if (cnt_reg != 7'd0 && can_rx != rx_prev_reg)
                cnt_reg <= 7'd1;
              else
                cnt_reg <= cnt_reg + 7'd1;
              if (cnt_reg == {4'd0, `CBPE_FLAG_LEN} - 7'd1 &&
                  (cnt_reg == 7'd0 || can_rx == rx_prev_reg))
              begin
                state_reg <= S_DWAIT;
                cnt_reg <= 7'd0;
              end
            end
            else
            begin
              cnt_reg <= cnt_reg + 7'd1;
              if (cnt_reg == {4'd0, `CBPE_FLAG_LEN} - 7'd1)
              begin
                state_reg <= S_DWAIT;
                drive_reg <= 1'b1;
                cnt_reg <= 7'd0;
              end
            end
            txing_reg <= 1'b0;
          end
          S_DWAIT:
          begin
            drive_reg <= 1'b1;
            if (can_rx)
            begin
              state_reg <= S_DELIM;
              cnt_reg <= 7'd0;
            end
            else if (cnt_reg == 7'd7)
            begin
              // too long a dominant run deforms the frame
              state_reg <= S_FLAG;
              drive_reg <= passive_reg;
              cnt_reg <= 7'd0;
            end
            else
              cnt_reg <= cnt_reg + 7'd1;
          end
          S_DELIM:
          begin
            cnt_reg <= cnt_reg + 7'd1;
            if (!can_rx)
            begin
              ebits_reg[3] <= 1'b1;
              state_reg <= S_FLAG;
              drive_reg <= use_passive;
              passive_reg <= use_passive;
              cnt_reg <= 7'd0;
            end
            else if (cnt_reg == {4'd0, `CBPE_DELIM_LEN} - 7'd1)
            begin
              state_reg <= S_INTER;
              is_ovl_reg <= 1'b0;
              cnt_reg <= 7'd0;
            end
          end
          S_INTER:
          begin
            cnt_reg <= cnt_reg + 7'd1;
            if (!can_rx)
            begin
              ovl_reg <= 1'b1;
              is_ovl_reg <= 1'b1;
              state_reg <= S_FLAG;
              drive_reg <= 1'b0;
              passive_reg <= 1'b0;
              cnt_reg <= 7'd0;
            end
            else if (cnt_reg == {5'd0, `CBPE_INTER_LEN} - 7'd1)
              state_reg <= S_IDLE;
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule // cbpe_engine
`default_nettype wire

//--- cbpe_map.vh
// constants for the can bit protocol engine: field lengths, crc, timing
// assumes a bit-timing unit that supplies one sample tick per bit period
// Operation
// - dominant level while idle starts a frame
// - transmit only from idle; hard sync at start
// - recessive sent, dominant seen: lose arbitration
// - identifier msb first, request bit last
// - insert opposite bit after five equal bits
// - drop stuff bit; wrong level is stuff error
// - fixed fields and error frames unstuffed
// - driven level held for whole bit
// - bit, stuff, form error: flag next bit
// - crc error flag after acknowledge delimiter
// - passive flag ends on six equal bits
// - after flag await recessive, send seven more
// - deviation in error frame restarts error frame
// - dominant in intermission starts overload next bit
// - overload no retransmit; deviation gives error frame
// - transmitted level mismatch is bit error
// - crc15 over destuffed bits, poly 0x4599
// - receiver compares received crc, flags mismatch
// - dominant in delimiters or end is form error
// - corrupted own frame queued for retransmission
// - active flag is six dominant bits
// - no frame start during three-bit intermission
// - seven recessive end bits, stuffing off
// - passive flag once a counter exceeds 127
`ifndef CBPE_MAP_VH
`define CBPE_MAP_VH
`define CBPE_STUFF_LEN    3'd5
`define CBPE_FLAG_LEN     3'd6
`define CBPE_DELIM_LEN    3'd7
`define CBPE_EOF_LEN      3'd7
`define CBPE_INTER_LEN    2'd3
`define CBPE_PASSIVE_LIM  8'd127
`define CBPE_CRC_POLY     15'h4599
`define CBPE_CRC_RST      15'h0000
`define CBPE_ID_LEN       4'd11
`define CBPE_CRC_LEN      4'd15
`define CBPE_BIT_TIME_NS  1000
`define CBPE_CLK_NS       10
`endif

//--- cbpe_crc15.v
// serial crc15 register for the bit engine
// assumes one destuffed bit per enable from the frame logic
`timescale 1ns/100ps
`default_nettype none
`include "cbpe_map.vh"
module cbpe_crc15
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clear,
  input  wire        shift_en,
  input  wire        bit_in,
  output wire [14:0] crc
);
  reg  [14:0] crc_reg;
  wire        fb;
  assign fb  = bit_in ^ crc_reg[14];
  assign crc = crc_reg;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      crc_reg <= `CBPE_CRC_RST;
    else if (clear)
      crc_reg <= `CBPE_CRC_RST;
    else if (shift_en)
      // modulo-2 division step, one destuffed bit at a time
      crc_reg <= {crc_reg[13:0], 1'b0} ^ (fb ? `CBPE_CRC_POLY : 15'h0000);
  end
endmodule // cbpe_crc15
`default_nettype wire

//--- cbpe_peer.sv
// peer node model: plays one stuffed frame onto the wired-and bus
// assumes the bench shares bit_tick and calls build off the clock edge
`timescale 1ns/100ps
`default_nettype none
module cbpe_peer
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic bit_tick,
  output var  logic peer_tx
);
  logic [199:0] seq;
  int           len = 0;
  int           pos = 0;

  // mode -1 build only, 1 bad crc, 2 bad stuff bit, 3 dominant intermission
  task automatic build(input logic [10:0] id, input logic [7:0] data,
                       input int mode);
    logic [26:0] raw;
    logic [14:0] crc;
    logic        b;
    int          run;
    raw = {1'b0, id, 7'h01, data};
    crc = 15'h0000;
    len = 0;
    run = 0;
    for (int i = 0; i < 42; i++)
    begin
      b = (i < 27) ? raw[26 - i] : crc[41 - i] ^ (mode == 1 && i == 41);
      if (i < 27)
        crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? 15'h4599 : 15'h0);
      run = (len > 0 && b == seq[len - 1]) ? run + 1 : 1;
      seq[len] = b;
      len++;
      if (run == 5 && mode == 2)
        break;
      if (run == 5)
      begin
        seq[len] = ~b;
        len++;
        run = 1;
      end
    end
    seq[len +: 11] = (mode == 2) ? 11'h000 : {mode != 3, 10'h3ff};
    len += (mode == 2) ? 1 : 10 + (mode == 3);
    pos = (mode < 0) ? len : 0;
  endtask

  // a finished peer leaves the line at the recessive pull level
  always @(posedge core_clk or posedge rst)
    if (rst)
      peer_tx <= 1'b1;
    else if (bit_tick)
    begin
      peer_tx <= (pos < len) ? seq[pos] : 1'b1;
      pos <= pos + 1;
    end
endmodule // cbpe_peer
`default_nettype wire

//--- cbpe_engine_props.sv
// port assertions for the bit engine
// assumes one clock domain and async active-high reset; bound below
`timescale 1ns/100ps
`default_nettype none
module cbpe_engine_props
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       bit_tick,
  input wire logic       can_rx,
  input wire logic       can_tx,
  input wire logic       hard_sync,
  input wire logic       tx_req,
  input wire logic       tx_done,
  input wire logic       tx_retry,
  input wire logic       arb_lost,
  input wire logic [7:0] tx_err_cnt,
  input wire logic [7:0] rx_err_cnt,
  input wire logic       err_bit,
  input wire logic       err_stuff,
  input wire logic       err_form,
  input wire logic       overload_seen,
  input wire logic       bus_idle
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic passive = (tx_err_cnt > 8'd127) || (rx_err_cnt > 8'd127);
  logic [3:0] rec_run_reg;

  // saturating count of consecutive recessive bus samples
  always @(posedge core_clk or posedge rst)
    if (rst)
      rec_run_reg <= 4'h0;
    else if (bit_tick)
      rec_run_reg <= can_rx ? rec_run_reg + {3'h0, rec_run_reg != 4'hf}
                            : 4'h0;

  sequence flag_start;
    ##[0:1] !can_tx;
  endsequence
  sequence quiet;
    can_tx [*8];
  endsequence

  nrz_hold_a: assert property ($changed(can_tx) |->
    $past(bit_tick) || $past(bit_tick, 2))
    else $error("bus drive moved between bit ticks");
  sof_sync_a: assert property (bit_tick && bus_idle && !can_rx |-> hard_sync)
    else $error("no hard sync on dominant idle bit");
  start_idle_a: assert property (bit_tick && bus_idle && tx_req && can_rx |=> !can_tx)
    else $error("no start bit from idle request");
  arb_cause_a: assert property (arb_lost |-> $past(can_tx) && !$past(can_rx))
    else $error("arbitration loss without overridden bit");
  bit_cause_a: assert property (err_bit |-> $past(can_tx) != $past(can_rx))
    else $error("bit error with matching levels");
  form_cause_a: assert property (err_form |-> !$past(can_rx))
    else $error("form error without dominant sample");
  active_flag_a: assert property ((err_bit || err_stuff || err_form || tx_retry)
    && !passive |-> flag_start)
    else $error("active error flag late");
  passive_flag_a: assert property ((err_bit || err_stuff || err_form) && passive
    |-> ##1 quiet)
    else $error("passive flag drove dominant");
  overload_flag_a: assert property (overload_seen |-> flag_start)
    else $error("overload flag late");
  eof_done_a: assert property (tx_done |-> rec_run_reg >= 4'd7)
    else $error("done before seven recessive bits");
endmodule // cbpe_engine_props

bind cbpe_engine cbpe_engine_props i_props
(
  .core_clk, .rst, .bit_tick, .can_rx, .can_tx, .hard_sync, .tx_req,
  .tx_done, .tx_retry, .arb_lost, .tx_err_cnt, .rx_err_cnt, .err_bit,
  .err_stuff, .err_form, .overload_seen, .bus_idle
);
`default_nettype wire

//--- can_bit_protocol_engine_bench.sv
// bench: engine and one peer node on a wired-and bus, four clocks a bit
// assumes no other node acknowledges, so own frames keep a recessive ack
`timescale 1ns/100ps
`default_nettype none
module can_bit_protocol_engine_bench;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic             bit_tick = 1'b0;
  logic [1:0]       tick_cnt = 2'h0;
  logic             tx_req = 1'b0;
  logic [10:0]      tx_id = 11'h000;
  logic [63:0]      tx_data = 64'h0;
  logic [7:0]       tx_err_cnt = 8'h00;
  logic [7:0]       rx_err_cnt = 8'h00;
  logic             bus_log [0:4095];
  logic [10:0]      got_id;
  logic [63:0]      got_data;
  int               ev [7] = '{default: 0};
  int               nb = 0;
  int               cycles = 0;
  int               mismatches = 0;
  int               samples_checked = 0;
  wire logic        can_tx, peer_tx, tx_done, tx_retry, arb_lost, rx_valid;
  wire logic        err_stuff, err_crc, overload_seen, bus_idle;
  wire logic [10:0] rx_id;
  wire logic [63:0] rx_data;
  wire logic        can_rx = can_tx & peer_tx;
  wire logic [6:0]  pulses = {overload_seen, err_crc, err_stuff, rx_valid,
                              arb_lost, tx_retry, tx_done};

  cbpe_engine i_dut
  (
    .core_clk(core_clk), .rst(rst), .bit_tick(bit_tick), .can_rx(can_rx),
    .can_tx(can_tx), .hard_sync(), .tx_req(tx_req), .tx_id(tx_id),
    .tx_rtr(1'b0), .tx_dlc(4'h1), .tx_data(tx_data), .tx_done(tx_done),
    .tx_retry(tx_retry), .arb_lost(arb_lost), .rx_id(rx_id), .rx_rtr(),
    .rx_dlc(), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_err_cnt(tx_err_cnt), .rx_err_cnt(rx_err_cnt), .err_bit(),
    .err_stuff(err_stuff), .err_crc(err_crc), .err_form(),
    .overload_seen(overload_seen), .bus_idle(bus_idle)
  );
  cbpe_peer i_peer
  (
    .core_clk(core_clk), .rst(rst), .bit_tick(bit_tick), .peer_tx(peer_tx)
  );

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h2);
    cycles <= cycles + 1;
    if (bit_tick)
      bus_log[nb] <= can_rx;
    nb <= nb + bit_tick;
    if (rx_valid)
    begin
      got_id <= rx_id;
      got_data <= rx_data;
    end
    foreach (ev[i])
      ev[i] <= ev[i] + pulses[i];
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk iff bit_tick);
    @(negedge core_clk);
  endtask

  task automatic await(input int k, input int base);
    for (int i = 0; i < 300 && ev[k] == base; i++)
      ticks(1);
    check("event count", base + 1, ev[k]);
  endtask

  task automatic settle;
    for (int i = 0; i < 300 && !bus_idle; i++)
      ticks(1);
    ticks(3);
  endtask

  function automatic logic [7:0] seg(input int at);
    for (int i = 0; i < 8; i++)
      seg[7 - i] = bus_log[at + i];
  endfunction

  function automatic int sof(input int s);
    sof = s;
    while (bus_log[sof] !== 1'b0 && sof < s + 40)
      sof++;
  endfunction

  task automatic request(input logic [10:0] id, input logic [7:0] data);
    @(posedge core_clk);
    tx_id <= id;
    tx_data <= {data, 56'h0};
    tx_req <= 1'b1;
  endtask

  task automatic t_own_frame;
    int   s;
    logic bad;
    s = nb;
    bad = 1'b0;
    i_peer.build(11'h07f, 8'hf0, -1);
    request(11'h07f, 8'hf0);
    await(0, ev[0]);
    @(posedge core_clk);
    tx_req <= 1'b0;
    s = sof(s);
    for (int i = 0; i < i_peer.len; i++)
      bad |= bus_log[s + i] !== i_peer.seq[i];
    check("own frame bits", 0, bad);
    settle();
  endtask

  // both start in the same bit; ids differ only in the last id bit
  task automatic t_arbitration;
    int b3;
    b3 = ev[3];
    i_peer.build(11'h100, 8'ha5, 0);
    request(11'h101, 8'h3c);
    await(2, ev[2]);
    await(3, b3);
    check("received id", 11'h100, got_id);
    check("received data", 64'ha5, got_data);
    await(0, ev[0]);
    @(posedge core_clk);
    tx_req <= 1'b0;
    settle();
  endtask

  task automatic t_bad_crc;
    int s;
    int b3;
    s = nb;
    b3 = ev[3];
    i_peer.build(11'h2a5, 8'h5a, 1);
    await(5, ev[5]);
    settle();
    s = sof(s) + i_peer.len - 9;
    check("crc flag bits", 8'hc0, seg(s));
    check("delimiter bit", 1, bus_log[s + 8]);
    check("no delivery", b3, ev[3]);
  endtask

  task automatic t_stuff_err;
    logic [15:0] cnt [3] = '{16'h007f, 16'h8000, 16'h0080};
    logic [7:0]  exp [3] = '{8'h01, 8'h7f, 8'h7f};
    int          s;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk);
      {tx_err_cnt, rx_err_cnt} <= cnt[k];
      s = nb;
      @(negedge core_clk);
      i_peer.build(11'h07f, 8'h00, 2);
      await(4, ev[4]);
      settle();
      check("stuff flag bits", exp[k], seg(sof(s) + 5));
    end
  endtask

  task automatic t_overload;
    int s;
    int b1;
    s = nb;
    b1 = ev[1];
    @(posedge core_clk);
    {tx_err_cnt, rx_err_cnt} <= 16'h0000;
    @(negedge core_clk);
    i_peer.build(11'h155, 8'hc3, 3);
    await(3, ev[3]);
    await(6, ev[6]);
    settle();
    check("overload bits", 8'h01, seg(sof(s) + i_peer.len - 1));
    check("no resend", b1, ev[1]);
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    ticks(12);
    t_own_frame();
    t_arbitration();
    t_bad_crc();
    t_stuff_err();
    t_overload();
    stop_test();
  end
endmodule // can_bit_protocol_engine_bench
`default_nettype wire
